// file: common/sacc_pkg.sv
package sacc_pkg;
  // Converter resolution and result codes
  localparam int RES_BITS = 14;
  localparam logic [13:0] NEG_CODE = 14'h2000;
  localparam logic [13:0] POS_MAX_CODE = 14'h1FFF;
  localparam logic [13:0] SAR_MSB_TRIAL = 14'h2000;
  localparam logic [3:0] MSB_INDEX = 4'hD;

  // Conversion timing: period and target conversion time in ns
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_CONV_NS = 260;
  localparam int CONV_CYCLES = T_CONV_NS / CLK_PERIOD_NS;
  localparam int STEP_CYCLES = CONV_CYCLES / RES_BITS;

  // Result buffer
  localparam int FIFO_DEPTH = 8;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;

  // Control register fields and reset value
  localparam int CTRL_SW_START = 0;
  localparam int CTRL_FIFO_EN = 1;
  localparam int CTRL_HW_EN = 2;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Span levels driven to the reference buffer
  localparam logic [1:0] GAIN_0DB = 2'h0;
  localparam logic [1:0] GAIN_M3DB = 2'h1;
  localparam logic [1:0] GAIN_M6DB = 2'h2;
  localparam logic [1:0] GAIN_M9DB = 2'h3;

  typedef enum logic [1:0] {S_IDLE, S_CONV, S_LATCH} sacc_state_e;

  typedef struct packed {
    logic oor;
    logic [13:0] code;
  } sacc_result_s;
endpackage

// file: src/sacc_fifo.sv
`timescale 1ns/1ps
module sacc_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  // Honest flags: full blocks the writer, empty blocks the reader
  assign in_ready = (cnt_q != PW'(0) + (PW+1)'(0)) ? (cnt_q < (PW+1)'(DEPTH))
                                                    : 1'b1;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and level update
  always_comb begin
    wr_d = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (PW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (PW+1)'(cnt_q - 1'b1);
    end
  end

  // Entry storage, written at the write pointer only
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_comb begin
      mem_d[i] = (push && wr_q == PW'(i)) ? in_data : mem_q[i];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_q[i] <= '0;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: src/sacc_top.sv
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - A falling edge on conversion_start_n begins a conversion.
// - Start edges during a running conversion are ignored; no abort.
// - busy is low throughout each conversion, high otherwise.
// - Result appears in parallel on result_bits; result_msb is the MSB.
// - The SAR decides one bit per step, MSB first down to LSB.
// - At conversion end the SAR word, with its MSB inverted, goes to the output latches.
// - Overrange shows as out_of_range_flag high with result_msb low.
// - Range selects pick 0, -3, -6 or -9 dB span.
// - nap_request_n low powers down conversion, reference stays on.
// - sleep_request_n low powers down everything, reference too.
// - Results are two's complement, zero at mid-scale input.
// - Flag also rises at the most negative code; with MSB high, underrange.
module sacc_top #(
  parameter int STEP_DIV = sacc_pkg::STEP_CYCLES,
  parameter int FIFO_DEPTH = sacc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sacc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conversion control pins
  input wire logic conversion_start_n,
  input wire logic range_select_0,
  input wire logic range_select_1,
  input wire logic nap_request_n,
  input wire logic sleep_request_n,
  // Analog front end
  input wire logic comparator_high,
  input wire logic over_range_cmp,
  output logic [13:0] dac_trial,
  output logic [1:0] range_level,
  output logic conv_power_en,
  output logic ref_power_en,
  // Result pins
  output logic busy,
  output logic [13:0] result_bits,
  output logic result_msb,
  output logic out_of_range_flag
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  sacc_pkg::sacc_state_e state_q, state_d;
  logic [13:0] sar_q, sar_d;
  logic [3:0] idx_q, idx_d;
  logic [7:0] div_q, div_d;
  logic start_prev_q;
  logic busy_q, busy_d;
  logic [13:0] res_q, res_d;
  logic msb_q, msb_d, oor_q, oor_d;
  logic [15:0] count_q, count_d;
  logic [1:0] range_q, range_d;
  logic conv_pwr_q, conv_pwr_d, ref_pwr_q, ref_pwr_d;
  logic fifo_en_q, fifo_en_d, hw_en_q, hw_en_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic step_en, start_fall, powered, go, latch_go, sw_start;
  logic setup, done, hit;
  logic [13:0] code2c;
  sacc_pkg::sacc_result_s res_word, head;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [LW-1:0] fifo_level;

  // Free-running step divider standing in for the trimmed oscillator
  always_comb begin
    step_en = (div_q == 8'h00);
    div_d = step_en ? 8'(STEP_DIV - 1) : 8'(div_q - 8'h01);
  end

  // Event and power decode from the pins
  assign start_fall = start_prev_q && !conversion_start_n;
  assign powered = nap_request_n && sleep_request_n;
  assign go = (state_q == sacc_pkg::S_IDLE) && powered
              && ((start_fall && hw_en_q) || sw_start);
  assign code2c = {~sar_q[13], sar_q[12:0]};
  assign latch_go = (state_q == sacc_pkg::S_LATCH)
                    && (!fifo_en_q || fifo_in_ready);

  // Conversion sequencer; a full buffer holds the latch step back
  always_comb begin
    state_d = state_q;
    sar_d = sar_q;
    idx_d = idx_q;
    res_d = res_q;
    msb_d = msb_q;
    oor_d = oor_q;
    count_d = count_q;
    unique case (state_q)
      sacc_pkg::S_IDLE: begin
        if (go) begin
          state_d = sacc_pkg::S_CONV;
          sar_d = sacc_pkg::SAR_MSB_TRIAL;
          idx_d = sacc_pkg::MSB_INDEX;
        end
      end
      sacc_pkg::S_CONV: begin
        if (step_en) begin
          sar_d[idx_q] = comparator_high;
          if (idx_q == 4'h0) begin
            state_d = sacc_pkg::S_LATCH;
          end else begin
            sar_d[4'(idx_q - 4'h1)] = 1'b1;
            idx_d = 4'(idx_q - 4'h1);
          end
        end
      end
      sacc_pkg::S_LATCH: begin
        if (latch_go) begin
          state_d = sacc_pkg::S_IDLE;
          count_d = 16'(count_q + 16'h0001);
          if (over_range_cmp) begin
            res_d = sacc_pkg::POS_MAX_CODE;
            oor_d = 1'b1;
          end else begin
            res_d = code2c;
            oor_d = (code2c == sacc_pkg::NEG_CODE);
          end
          msb_d = res_d[13];
        end
      end
    endcase
    busy_d = (state_d == sacc_pkg::S_IDLE);
  end

  // Span select and power gating follow the pins one cycle later
  always_comb begin
    unique case ({range_select_1, range_select_0})
      2'b11: range_d = sacc_pkg::GAIN_0DB;
      2'b01: range_d = sacc_pkg::GAIN_M3DB;
      2'b10: range_d = sacc_pkg::GAIN_M6DB;
      2'b00: range_d = sacc_pkg::GAIN_M9DB;
    endcase
    conv_pwr_d = powered;
    ref_pwr_d = sleep_request_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= sacc_pkg::S_IDLE;
      sar_q <= '0;
      idx_q <= '0;
      div_q <= '0;
      start_prev_q <= 1'b1;
      busy_q <= 1'b1;
      res_q <= '0;
      msb_q <= 1'b0;
      oor_q <= 1'b0;
      count_q <= '0;
      range_q <= sacc_pkg::GAIN_0DB;
      conv_pwr_q <= 1'b0;
      ref_pwr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sar_q <= sar_d;
      idx_q <= idx_d;
      div_q <= div_d;
      start_prev_q <= conversion_start_n;
      busy_q <= busy_d;
      res_q <= res_d;
      msb_q <= msb_d;
      oor_q <= oor_d;
      count_q <= count_d;
      range_q <= range_d;
      conv_pwr_q <= conv_pwr_d;
      ref_pwr_q <= ref_pwr_d;
    end
  end

  // Each latched result is also queued for software
  assign res_word = '{oor: oor_d, code: res_d};

  sacc_fifo #(
    .WIDTH($bits(sacc_pkg::sacc_result_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(latch_go && fifo_en_q),
    .in_ready(fifo_in_ready),
    .in_data(res_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(head),
    .level(fifo_level)
  );

  // APB decode: data is staged in setup so prdata leaves a flop
  assign setup = psel && !penable;
  assign done = psel && penable && pready_q;
  assign hit = (paddr == sacc_pkg::OFS_CTRL) || (paddr == sacc_pkg::OFS_STATUS)
               || (paddr == sacc_pkg::OFS_DATA)
               || (paddr == sacc_pkg::OFS_COUNT);
  assign sw_start = done && pwrite && (paddr == sacc_pkg::OFS_CTRL)
                    && pwdata[sacc_pkg::CTRL_SW_START];
  assign fifo_pop = done && !pwrite && (paddr == sacc_pkg::OFS_DATA);

  // Register file; reads of DATA pop only when the access completes
  always_comb begin
    prdata_d = prdata_q;
    pready_d = setup;
    pslverr_d = setup && !hit;
    fifo_en_d = fifo_en_q;
    hw_en_d = hw_en_q;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          sacc_pkg::OFS_CTRL: begin
            prdata_d[sacc_pkg::CTRL_FIFO_EN] = fifo_en_q;
            prdata_d[sacc_pkg::CTRL_HW_EN] = hw_en_q;
          end
          sacc_pkg::OFS_STATUS: begin
            prdata_d[0] = !busy_q;
            prdata_d[1] = !conv_pwr_q;
            prdata_d[2] = !ref_pwr_q;
            prdata_d[5:4] = range_q;
            prdata_d[8 +: LW] = fifo_level;
          end
          sacc_pkg::OFS_DATA: begin
            prdata_d[31] = fifo_out_valid;
            prdata_d[14:0] = fifo_out_valid ? head : 15'h0000;
          end
          sacc_pkg::OFS_COUNT: prdata_d[15:0] = count_q;
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
    if (done && pwrite && paddr == sacc_pkg::OFS_CTRL) begin
      fifo_en_d = pwdata[sacc_pkg::CTRL_FIFO_EN];
      hw_en_d = pwdata[sacc_pkg::CTRL_HW_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      fifo_en_q <= sacc_pkg::CTRL_RESET[0];
      hw_en_q <= sacc_pkg::CTRL_RESET[1];
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      fifo_en_q <= fifo_en_d;
      hw_en_q <= hw_en_d;
    end
  end

  // Every output comes straight from a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dac_trial = sar_q;
  assign range_level = range_q;
  assign conv_power_en = conv_pwr_q;
  assign ref_power_en = ref_pwr_q;
  assign busy = busy_q;
  assign result_bits = res_q;
  assign result_msb = msb_q;
  assign out_of_range_flag = oor_q;

  // Checks on the sequencer and pins
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_busy_low: assert property (go |=> !busy_q[*3])
    else $error("start did not drop busy");
  a_no_restart: assert property ((state_q == sacc_pkg::S_CONV && !step_en)
    |=> $stable(idx_q) && $stable(sar_q))
    else $error("running conversion disturbed");
  a_busy_window: assert property ((go && (!fifo_en_q || fifo_in_ready))
    |=> !busy_q
    ##[14:60] busy_q)
    else $error("busy window wrong");
  a_msb_first: assert property (go |=> idx_q == 4'hD && sar_q == 14'h2000)
    else $error("conversion did not begin at msb");
  a_latch_copy: assert property ((latch_go && !over_range_cmp) |=>
    result_bits == {~$past(sar_q[13]), $past(sar_q[12:0])}
    && result_msb == result_bits[13])
    else $error("latch does not hold sar word");
  a_over_flag: assert property ((latch_go && over_range_cmp) |=>
    out_of_range_flag && !result_msb)
    else $error("overrange not flagged");
  a_under_flag: assert property ((latch_go && !over_range_cmp
    && sar_q == 14'h0000) |=> out_of_range_flag && result_msb)
    else $error("underrange not flagged");
  a_range_map: assert property (range_select_0 && !range_select_1
    |=> range_level == 2'h1)
    else $error("span decode wrong");
  a_nap_power: assert property (!nap_request_n && sleep_request_n && busy_q
    |=> !conv_power_en && ref_power_en && busy_q)
    else $error("nap power wrong");
  a_sleep_power: assert property (!sleep_request_n
    |=> !conv_power_en && !ref_power_en)
    else $error("sleep power wrong");
  a_apb_ready: assert property (setup |=> pready && !$past(penable))
    else $error("apb answer late");

  c_conversion: cover property (go ##[14:60] $rose(busy_q));
  c_overrange: cover property (latch_go && over_range_cmp);
  c_fifo_stall: cover property (state_q == sacc_pkg::S_LATCH && !latch_go);
  c_nap_start: cover property (!nap_request_n && start_fall);
endmodule

// file: verif/sacc_host_model.sv
`timescale 1ns/1ps
// Far side: an ideal analog input and a host that captures results
module sacc_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stimulus from the bench
  input wire logic [13:0] target,
  input wire logic over_in,
  // Converter side
  input wire logic [13:0] dac_trial,
  input wire logic busy,
  input wire logic [13:0] result_bits,
  input wire logic out_of_range_flag,
  output logic comparator_high,
  output logic over_range_cmp,
  // Last captured word
  output logic [14:0] captured
);
  logic busy_q;

  // Ideal comparator, so the SAR must settle exactly on the target
  assign comparator_high = (target >= dac_trial);
  assign over_range_cmp = over_in;

  // Capture after busy rises, well before the next result is due
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b1;
      captured <= 15'h0000;
    end else begin
      busy_q <= busy;
      if (busy && !busy_q) captured <= {out_of_range_flag, result_bits};
    end
  end
endmodule

// file: verif/sacc_top_tb_top.sv
`timescale 1ns/1ps
module sacc_top_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic start_n, rs0, rs1, nap_n, slp_n, cmp_hi, ovr_cmp, over_in;
  logic [13:0] dac_trial, result_bits, target;
  logic [1:0] range_level;
  logic conv_pwr, ref_pwr, busy, result_msb, oor;
  logic [14:0] captured;
  logic [14:0] q[$];
  logic [13:0] tv[5] = '{14'h2000, 14'h3FFF, 14'h0000, 14'h1234, 14'h0001};
  int miscompares, compares;

  sacc_top #(.STEP_DIV(3), .FIFO_DEPTH(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conversion_start_n(start_n),
    .range_select_0(rs0), .range_select_1(rs1), .nap_request_n(nap_n),
    .sleep_request_n(slp_n), .comparator_high(cmp_hi),
    .over_range_cmp(ovr_cmp), .dac_trial(dac_trial),
    .range_level(range_level), .conv_power_en(conv_pwr),
    .ref_power_en(ref_pwr), .busy(busy), .result_bits(result_bits),
    .result_msb(result_msb), .out_of_range_flag(oor)
  );

  sacc_host_model host (
    .pclk(pclk), .presetn(presetn), .target(target), .over_in(over_in),
    .dac_trial(dac_trial), .busy(busy), .result_bits(result_bits),
    .out_of_range_flag(oor), .comparator_high(cmp_hi),
    .over_range_cmp(ovr_cmp), .captured(captured)
  );

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; an idle edge follows so calls never collide
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pulse();
    start_n <= 1'b0;
    @(posedge pclk);
    start_n <= 1'b1;
    @(posedge pclk);
  endtask

  // One conversion: sw = register start, re = restart try, pop = full FIFO
  task automatic conv(input logic [13:0] t, input logic ov, input logic sw,
                      input logic re, input logic pop);
    int n;
    logic [14:0] e;
    e = ov ? {1'b1, 14'h1FFF} : {t == 14'h0000, t ^ 14'h2000};
    target <= t;
    over_in <= ov;
    if (sw) apb(1'b1, sacc_pkg::OFS_CTRL, 32'h7);
    else pulse();
    n = 0;
    while (busy !== 1'b0 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    check(busy, 1'b0);
    check(dac_trial, 14'h2000);
    n = 0;
    if (re) begin
      repeat (4) @(posedge pclk);
      pulse();
      n = 6;
    end
    if (pop) begin
      repeat (100) @(posedge pclk);
      check(busy, 1'b0);
      apb(1'b0, sacc_pkg::OFS_DATA, 32'h0);
      check(r, {17'h10000, q.pop_front()});
    end
    while (busy !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    // 14 steps of 3 cycles from a free-running divider, plus the latch
    if (!pop) check(n >= 41 && n <= 43, 1'b1);
    check(result_bits, e[13:0]);
    check(result_msb, e[13]);
    check(oor, e[14]);
    repeat (20) @(posedge pclk);
    check(captured, e);
    check(busy, 1'b1);
    q.push_back(e);
  endtask

  // Hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    #100us;
    miscompares++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start_n = 1'b1;
    rs0 = 1'b1;
    rs1 = 1'b1;
    nap_n = 1'b1;
    slp_n = 1'b1;
    target = 14'h0000;
    over_in = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(busy, 1'b1);
    check(result_bits, 14'h0000);
    apb(1'b0, sacc_pkg::OFS_CTRL, 32'h0);
    check(r, 32'h6);
    for (int i = 0; i < 4; i++) begin
      rs0 <= ~i[1];
      rs1 <= ~i[0];
      repeat (2) @(posedge pclk);
      check(range_level, i[1:0]);
      apb(1'b0, sacc_pkg::OFS_STATUS, 32'h0);
      check(r[5:4], i[1:0]);
    end
    rs0 <= 1'b1;
    rs1 <= 1'b1;
    $display("reset and range tests done");
    foreach (tv[k]) conv(tv[k], 1'b0, 1'b0, 1'b0, 1'b0);
    conv(14'h3000, 1'b1, 1'b0, 1'b0, 1'b0);
    conv(14'h2ABC, 1'b0, 1'b0, 1'b1, 1'b0);
    conv(14'h0F0F, 1'b0, 1'b1, 1'b0, 1'b0);
    conv(14'h1555, 1'b0, 1'b0, 1'b0, 1'b1);
    $display("conversion tests done");
    apb(1'b0, sacc_pkg::OFS_STATUS, 32'h0);
    check(r[11:8], 4'h8);
    apb(1'b0, sacc_pkg::OFS_COUNT, 32'h0);
    check(r[15:0], 16'h0009);
    while (q.size() > 0) begin
      apb(1'b0, sacc_pkg::OFS_DATA, 32'h0);
      check(r, {17'h10000, q.pop_front()});
    end
    apb(1'b0, sacc_pkg::OFS_DATA, 32'h0);
    check(r, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1);
    check(r, 32'h0);
    // Pin start disabled: a falling edge must leave the converter idle
    apb(1'b1, sacc_pkg::OFS_CTRL, 32'h0);
    pulse();
    repeat (5) @(posedge pclk);
    check(busy, 1'b1);
    conv(14'h0ABC, 1'b0, 1'b1, 1'b0, 1'b0);
    $display("buffer tests done");
    nap_n <= 1'b0;
    repeat (2) @(posedge pclk);
    check({conv_pwr, ref_pwr}, 2'b01);
    apb(1'b0, sacc_pkg::OFS_STATUS, 32'h0);
    check(r[2:0], 3'h2);
    pulse();
    repeat (60) @(posedge pclk);
    check(busy, 1'b1);
    nap_n <= 1'b1;
    repeat (50) @(posedge pclk);
    conv(14'h2222, 1'b0, 1'b0, 1'b0, 1'b0);
    slp_n <= 1'b0;
    repeat (2) @(posedge pclk);
    check({conv_pwr, ref_pwr}, 2'b00);
    apb(1'b0, sacc_pkg::OFS_STATUS, 32'h0);
    check(r[2:0], 3'h6);
    pulse();
    repeat (60) @(posedge pclk);
    check(busy, 1'b1);
    // No start after sleep: reference recovery outlasts this run
    $display("power tests done");
    give_verdict();
  end
endmodule
